/* File: can_ctrl_pkg.sv */
// Shared constants and types of the CAN transceiver mode, wake and fault control.
// Assumes a single 250 MHz clock; all times are converted to cycles of that clock.
package can_ctrl_pkg;

  // Transceiver mode field codes.
  localparam logic [1:0] TRX_OFF = 2'h0;
  localparam logic [1:0] TRX_WAKE = 2'h1;
  localparam logic [1:0] TRX_RX_ONLY = 2'h2;
  localparam logic [1:0] TRX_NORMAL = 2'h3;
  localparam logic [1:0] TRX_MODE_RESET = TRX_OFF;

  typedef enum logic [2:0] {
    dev_normal,
    dev_stop,
    dev_sleep,
    dev_restart,
    dev_fail_safe
  } device_mode_e;

  typedef enum logic [1:0] {
    term_floating,
    term_ground,
    term_half_supply,
    term_fixed_2v5
  } termination_e;

  typedef enum logic [1:0] {
    wp_idle,
    wp_dom1,
    wp_rec,
    wp_dom2
  } wake_state_e;

  // Clock and times.
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_MIN_TIME_NS = 500;
  localparam int WAKE_MAX_TIME_NS = 1800;
  localparam int ENABLE_TIME_NS = 10000;
  localparam int TXD_TIMEOUT_US = 1000;
  localparam int BUS_TIMEOUT_US = 2000;
  localparam int SILENCE_TIME_US = 1000;

  localparam int WAKE_MIN_CYCLES = (WAKE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MAX_CYCLES = WAKE_MAX_TIME_NS / CLK_PERIOD_NS;
  localparam int ENABLE_CYCLES = (ENABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TXD_TIMEOUT_CYCLES = (TXD_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_TIMEOUT_CYCLES = (BUS_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SILENCE_CYCLES = (SILENCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter widths.
  localparam int TIMER_W = 20;
  localparam int WAKE_W = 10;

endpackage

/* File: pattern_if.sv */
// Carrier between the control block and its bus watchers.
// Assumes the owner drives the watched level and enable, and the watcher answers with hit.
`timescale 1ns/1ps
interface pattern_if;
  logic dominant;
  logic enable;
  logic hit;
  modport owner(output dominant, output enable, input hit);
  modport watcher(input dominant, input enable, output hit);
endinterface

/* File: dominant_timer.sv */
// Measures how long a level stays dominant while enabled.
// Assumes the level is synchronous to clk; hit holds while the time-out persists.
`timescale 1ns/1ps
module dominant_timer #(
  parameter int LIMIT = 16,
  parameter int W = 20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Watched level.
  pattern_if.watcher watch
);

  logic [W-1:0] cnt;
  wire run = watch.enable && watch.dominant;

  assign watch.hit = (cnt == W'(LIMIT + 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= '0;
    end else if (!watch.hit) begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

/* File: wake_pattern_detect.sv */
// Recognises the dominant, recessive, dominant wake pattern on the bus.
// Assumes the bus level is synchronous to clk; hit is a one-cycle pulse.
`timescale 1ns/1ps
module wake_pattern_detect #(
  parameter int MIN = 125,
  parameter int MAX = 450,
  parameter int W = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Watched bus level.
  pattern_if.watcher watch
);

  can_ctrl_pkg::wake_state_e state;
  logic [W-1:0] cnt;
  logic hit;

  wire dom = watch.dominant;
  wire phase_ok = cnt >= W'(MIN);
  wire rec_ok = cnt > W'(MIN);
  wire too_long = cnt >= W'(MAX - 1);

  assign watch.hit = hit;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= can_ctrl_pkg::wp_idle;
      cnt <= '0;
      hit <= 1'b0;
    end else if (!watch.enable) begin
      state <= can_ctrl_pkg::wp_idle;
      cnt <= '0;
      hit <= 1'b0;
    end else begin
      hit <= 1'b0;
      cnt <= W'(1);
      unique case (state)
        can_ctrl_pkg::wp_idle: begin
          if (dom) begin
            state <= can_ctrl_pkg::wp_dom1;
          end
        end
        can_ctrl_pkg::wp_dom1: begin
          if (dom && too_long) begin
            state <= can_ctrl_pkg::wp_idle;
          end else if (dom) begin
            cnt <= cnt + 1'b1;
          end else begin
            state <= phase_ok ? can_ctrl_pkg::wp_rec : can_ctrl_pkg::wp_idle;
          end
        end
        can_ctrl_pkg::wp_rec: begin
          if (!dom && too_long) begin
            state <= can_ctrl_pkg::wp_idle;
          end else if (!dom) begin
            cnt <= cnt + 1'b1;
          end else begin
            state <= rec_ok ? can_ctrl_pkg::wp_dom2 : can_ctrl_pkg::wp_dom1;
          end
        end
        can_ctrl_pkg::wp_dom2: begin
          if (dom && cnt == W'(MIN - 1)) begin
            hit <= 1'b1;
            state <= can_ctrl_pkg::wp_idle;
          end else if (dom) begin
            cnt <= cnt + 1'b1;
          end else begin
            state <= can_ctrl_pkg::wp_idle;
          end
        end
      endcase
    end
  end

endmodule

/* File: can_trx_ctrl.sv */
// Mode, wake-up and fault supervision of the high-speed CAN transceiver.
// Assumes all inputs are synchronous to clk and software bits arrive as plain ports.
//
// What this block does
// RULE1: Wake-capable selectable in stop, sleep, restart, normal; forced in fail-safe.
// RULE2: After a bus wake in wake-capable mode, receive output stays low until mode changes.
// RULE3: Wake needs dominant and recessive phases between the two wake times, then a dominant phase of the minimum wake time.
// RULE4: After a wake the mode field still reads the wake-capable code.
// RULE5: Software rearms by leaving wake-capable mode, then selecting it again.
// RULE6: Entering stop, sleep or fail-safe rearms wake detection automatically.
// RULE7: Wake in stop or normal raises interrupt, wake status and low receive output.
// RULE8: Wake in stop never moves the device to normal by itself.
// RULE9: Wake in stop enables a disabled watchdog when the on-wake bit is set.
// RULE10: Wake in sleep requests restart, drives receive low, raises no interrupt.
// RULE11: Wake from sleep, restart or fail-safe requests restart; stop and normal stay.
// RULE12: Termination follows transceiver mode, supply state and wake state.
// RULE13: Ground termination connects only after the silence time in wake-capable mode.
// RULE14: Transmit dominant past its time-out in normal mode forces the bus recessive.
// RULE15: A transmit time-out keeps the mode field and sets the CAN fault flag.
// RULE16: The transmitter resumes once the transmit input is recessive again.
// RULE17: Bus dominant past its time-out in normal or receive-only sets the fault flag.
// RULE18: The bus clamp time-out is always longer than the transmit time-out.
// RULE19: Supply undervoltage in normal or receive-only sets a flag and stops transmitting.
// RULE20: Transmitting resumes automatically when the supply recovers.
// RULE21: Undervoltage detection runs only while the upper mode bit is set.
// RULE22: Receive-only mode keeps delivering bus data even without transceiver supply.
// RULE23: Mode is off after reset; off mode ignores bus wake events.
// RULE24: Transmit waits for the enable time and the next recessive-to-dominant edge.
// RULE25: Mode codes are off 00, wake 01, receive-only 10, normal 11.
`timescale 1ns/1ps
module can_trx_ctrl #(
  parameter int TXD_TIMEOUT_CYCLES = can_ctrl_pkg::TXD_TIMEOUT_CYCLES,
  parameter int BUS_TIMEOUT_CYCLES = can_ctrl_pkg::BUS_TIMEOUT_CYCLES,
  parameter int SILENCE_CYCLES = can_ctrl_pkg::SILENCE_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Device state.
  input wire can_ctrl_pkg::device_mode_e device_mode,
  input wire logic watchdog_on_bus_wake,
  input wire logic watchdog_enabled,
  // Software control.
  input wire logic mode_write,
  input wire logic [1:0] mode_value,
  input wire logic can_fail_clear,
  input wire logic supply_low_clear,
  input wire logic wake_status_clear,
  input wire logic irq_clear,
  // Controller and analog side.
  input wire logic bus_transmit_in,
  input wire logic bus_dominant_in,
  input wire logic transceiver_supply_low,
  // Transceiver outputs.
  output logic [1:0] transceiver_mode,
  output logic bus_receive_out,
  output logic bus_drive_dominant,
  output can_ctrl_pkg::termination_e termination,
  // Status and events.
  output logic can_fail_flag,
  output logic transceiver_supply_low_flag,
  output logic wake_source_status,
  output logic irq_out_n,
  output logic restart_request,
  output logic watchdog_enable_request
);

  localparam int TW = can_ctrl_pkg::TIMER_W;
  localparam int BUS_LIMIT =
    (BUS_TIMEOUT_CYCLES > TXD_TIMEOUT_CYCLES) ? BUS_TIMEOUT_CYCLES : TXD_TIMEOUT_CYCLES + 1;

  pattern_if wake_watch();
  pattern_if txd_watch();
  pattern_if bus_watch();

  can_ctrl_pkg::device_mode_e prev_device_mode;
  can_ctrl_pkg::termination_e next_termination;
  logic [1:0] next_mode;
  logic woken;
  logic txd_hit_q;
  logic bus_hit_q;
  logic tx_gate;
  logic [TW-1:0] enable_cnt;
  logic [TW-1:0] silence_cnt;

  // Device mode decoding.
  wire in_normal = device_mode == can_ctrl_pkg::dev_normal;
  wire in_stop = device_mode == can_ctrl_pkg::dev_stop;
  wire in_sleep = device_mode == can_ctrl_pkg::dev_sleep;
  wire in_fail_safe = device_mode == can_ctrl_pkg::dev_fail_safe;
  wire dev_changed = device_mode != prev_device_mode;
  wire rearm_entry = dev_changed && (in_stop || in_sleep || in_fail_safe); // see RULE6

  // Transceiver mode decoding.
  wire mode_off = transceiver_mode == can_ctrl_pkg::TRX_OFF;
  wire mode_wake = transceiver_mode == can_ctrl_pkg::TRX_WAKE;
  wire mode_rx = transceiver_mode == can_ctrl_pkg::TRX_RX_ONLY;
  wire mode_normal = transceiver_mode == can_ctrl_pkg::TRX_NORMAL;

  // Software mode requests allowed per device mode.
  wire wake_allowed = !in_fail_safe; // see RULE1
  wire active_allowed = in_normal || in_stop;
  wire write_ok = mode_write && ((mode_value == can_ctrl_pkg::TRX_OFF)
    || (mode_value == can_ctrl_pkg::TRX_WAKE && wake_allowed)
    || (mode_value[1] && active_allowed));

  // Fail-safe forces wake-capable; otherwise an accepted write sets the field.
  assign next_mode = in_fail_safe ? can_ctrl_pkg::TRX_WAKE // see RULE1
    : (write_ok ? mode_value : transceiver_mode); // see RULE25

  // Wake detection runs only while wake-capable and armed; off mode ignores the bus.
  assign wake_watch.dominant = bus_dominant_in;
  assign wake_watch.enable = mode_wake && !woken; // see RULE23
  wire wake_hit = wake_watch.hit;

  // Transmit and bus time-out watchers.
  wire txd_dominant = !bus_transmit_in;
  assign txd_watch.dominant = txd_dominant;
  assign txd_watch.enable = mode_normal; // see RULE14
  assign bus_watch.dominant = bus_dominant_in;
  assign bus_watch.enable = transceiver_mode[1]; // see RULE17
  wire txd_hit = txd_watch.hit;
  wire fail_event = (txd_hit && !txd_hit_q) || (bus_watch.hit && !bus_hit_q); // see RULE15

  // Undervoltage is watched only in normal and receive-only.
  wire supply_low_active = transceiver_mode[1] && transceiver_supply_low; // see RULE21

  // Enable time after entering normal mode.
  wire enable_done = enable_cnt == TW'(can_ctrl_pkg::ENABLE_CYCLES);
  wire silence_done = silence_cnt == TW'(SILENCE_CYCLES);

  // Driver: gated by enable sequence, time-out and undervoltage.
  wire next_drive = mode_normal && tx_gate && !txd_hit // see RULE16
    && !supply_low_active && txd_dominant; // see RULE20

  // Receive output per mode.
  wire next_receive = mode_wake ? !woken // see RULE2
    : (transceiver_mode[1] ? !bus_dominant_in : 1'b1); // see RULE22

  // Termination per mode.
  always_comb begin
    next_termination = can_ctrl_pkg::term_floating;
    if (mode_normal) begin
      next_termination = can_ctrl_pkg::term_half_supply; // see RULE12
    end else if (mode_rx) begin
      next_termination = transceiver_supply_low ? can_ctrl_pkg::term_fixed_2v5
        : can_ctrl_pkg::term_half_supply;
    end else if (mode_wake && woken) begin
      next_termination = can_ctrl_pkg::term_fixed_2v5;
    end else if (mode_wake && silence_done) begin
      next_termination = can_ctrl_pkg::term_ground; // see RULE13
    end
  end

  // Wake reactions per device mode.
  wire wake_irq = wake_hit && (in_stop || in_normal); // see RULE7
  wire wake_restart = wake_hit && !in_stop && !in_normal; // see RULE11
  wire wake_watchdog = wake_hit && in_stop && watchdog_on_bus_wake && !watchdog_enabled;

  dominant_timer #(
    .LIMIT(TXD_TIMEOUT_CYCLES),
    .W(TW)
  ) txd_timer (
    .clk(clk),
    .reset_n(reset_n),
    .watch(txd_watch)
  );

  dominant_timer #(
    .LIMIT(BUS_LIMIT), // see RULE18
    .W(TW)
  ) bus_timer (
    .clk(clk),
    .reset_n(reset_n),
    .watch(bus_watch)
  );

  wake_pattern_detect #(
    .MIN(can_ctrl_pkg::WAKE_MIN_CYCLES),
    .MAX(can_ctrl_pkg::WAKE_MAX_CYCLES),
    .W(can_ctrl_pkg::WAKE_W)
  ) wake_detect ( // see RULE3
    .clk(clk),
    .reset_n(reset_n),
    .watch(wake_watch)
  );

  // Mode field and wake state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      transceiver_mode <= can_ctrl_pkg::TRX_MODE_RESET; // see RULE23
      prev_device_mode <= can_ctrl_pkg::dev_normal;
      woken <= 1'b0;
    end else begin
      transceiver_mode <= next_mode; // see RULE4
      prev_device_mode <= device_mode;
      if (wake_hit) begin
        woken <= 1'b1;
      end else if (next_mode != can_ctrl_pkg::TRX_WAKE || rearm_entry) begin
        woken <= 1'b0; // see RULE5
      end
    end
  end

  // Enable and silence timing.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_cnt <= '0;
      silence_cnt <= '0;
      tx_gate <= 1'b0;
    end else begin
      enable_cnt <= !mode_normal ? '0 : (enable_done ? enable_cnt : enable_cnt + 1'b1);
      silence_cnt <= !mode_wake ? '0 : (silence_done ? silence_cnt : silence_cnt + 1'b1);
      if (!mode_normal) begin
        tx_gate <= 1'b0;
      end else if (enable_done && !txd_dominant) begin
        tx_gate <= 1'b1; // see RULE24
      end
    end
  end

  // Pin outputs.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_drive_dominant <= 1'b0;
      bus_receive_out <= 1'b1;
      termination <= can_ctrl_pkg::term_floating;
    end else begin
      bus_drive_dominant <= next_drive; // see RULE19
      bus_receive_out <= next_receive;
      termination <= next_termination;
    end
  end

  // Sticky flags; a set in the cycle of a clear wins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txd_hit_q <= 1'b0;
      bus_hit_q <= 1'b0;
      can_fail_flag <= 1'b0;
      transceiver_supply_low_flag <= 1'b0;
      wake_source_status <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      txd_hit_q <= txd_hit;
      bus_hit_q <= bus_watch.hit;
      can_fail_flag <= fail_event || (can_fail_flag && !can_fail_clear); // see RULE17
      transceiver_supply_low_flag <= supply_low_active
        || (transceiver_supply_low_flag && !supply_low_clear); // see RULE19
      wake_source_status <= wake_hit || (wake_source_status && !wake_status_clear);
      irq_out_n <= !(wake_irq || (!irq_out_n && !irq_clear)); // see RULE10
    end
  end

  // Event pulses to the device mode and watchdog logic.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      restart_request <= 1'b0;
      watchdog_enable_request <= 1'b0;
    end else begin
      restart_request <= wake_restart; // see RULE8
      watchdog_enable_request <= wake_watchdog; // see RULE9
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  fail_safe_wake_a: assert property (in_fail_safe |=> transceiver_mode == 2'h1) // see RULE1
    else $error("Fail-safe did not force wake-capable mode.");
  woken_rx_low_a: assert property (wake_hit ##1 mode_wake |=> !bus_receive_out) // see RULE2
    else $error("Receive output not low after wake.");
  wake_code_a: assert property (wake_hit && !mode_write && !in_fail_safe // see RULE4
    && mode_wake |=> transceiver_mode == 2'h1)
    else $error("Mode field changed after wake.");
  wake_irq_a: assert property (wake_irq |=> !irq_out_n && wake_source_status) // see RULE7
    else $error("Wake in stop or normal not signalled.");
  stop_stays_a: assert property (wake_hit && in_stop |=> !restart_request) // see RULE8
    else $error("Wake in stop requested restart.");
  sleep_wake_a: assert property (wake_hit && in_sleep && irq_out_n // see RULE10
    |=> restart_request && irq_out_n)
    else $error("Sleep wake handled wrongly.");
  watchdog_wake_a: assert property (wake_hit && in_stop && watchdog_on_bus_wake // see RULE9
    && !watchdog_enabled |=> watchdog_enable_request)
    else $error("Watchdog not enabled on bus wake.");
  txd_block_a: assert property (txd_hit |=> !bus_drive_dominant) // see RULE14
    else $error("Driver active after transmit time-out.");
  txd_fail_a: assert property ($rose(txd_hit) |=> can_fail_flag) // see RULE15
    else $error("Fault flag not set on transmit time-out.");
  uv_block_a: assert property (supply_low_active // see RULE19
    |=> !bus_drive_dominant && transceiver_supply_low_flag)
    else $error("Undervoltage not handled.");
  rx_only_data_a: assert property (mode_rx // see RULE22
    |=> bus_receive_out == !$past(bus_dominant_in))
    else $error("Receive-only data lost.");
  off_ignores_a: assert property (mode_off ##1 mode_off |-> !wake_hit) // see RULE23
    else $error("Wake seen in off mode.");
  silence_gnd_a: assert property ($rose(mode_wake) // see RULE13
    |=> termination != can_ctrl_pkg::term_ground)
    else $error("Ground termination before silence time.");

  // Termination, rearm and fault bookkeeping.
  wake_term_a: assert property (mode_wake && woken // see RULE12
    |=> termination == can_ctrl_pkg::term_fixed_2v5)
    else $error("Termination not fixed after wake.");
  off_float_a: assert property (mode_off // see RULE12
    |=> termination == can_ctrl_pkg::term_floating)
    else $error("Bus not floating in off mode.");
  rx_term_a: assert property (mode_rx && transceiver_supply_low // see RULE12
    |=> termination == can_ctrl_pkg::term_fixed_2v5)
    else $error("Receive-only undervoltage termination wrong.");
  ground_term_a: assert property (mode_wake && !woken && silence_done // see RULE13
    |=> termination == can_ctrl_pkg::term_ground)
    else $error("Ground termination missing after silence time.");
  rearm_clear_a: assert property (rearm_entry && !wake_hit // see RULE6
    |=> !woken)
    else $error("Device mode entry did not rearm wake detection.");
  sleep_status_a: assert property (wake_hit && in_sleep // see RULE10
    |=> wake_source_status)
    else $error("Sleep wake source not recorded.");
  restart_wake_a: assert property (wake_hit && !in_stop && !in_normal && irq_out_n // see RULE11
    |=> restart_request && irq_out_n)
    else $error("Wake outside stop or normal handled wrongly.");
  txd_mode_a: assert property (txd_hit && !mode_write && !in_fail_safe // see RULE15
    |=> transceiver_mode == $past(transceiver_mode))
    else $error("Mode field changed on transmit time-out.");
  bus_fail_a: assert property ($rose(bus_watch.hit) // see RULE17
    |=> can_fail_flag)
    else $error("Fault flag not set on bus clamping.");
  uv_gate_a: assert property (!transceiver_mode[1] && !transceiver_supply_low_flag // see RULE21
    |=> !transceiver_supply_low_flag)
    else $error("Undervoltage flagged outside active modes.");
  enable_wait_a: assert property (mode_normal && !enable_done // see RULE24
    |=> !bus_drive_dominant)
    else $error("Driver active before enable time.");

  wake_stop_c: cover property (wake_hit && in_stop);
  wake_sleep_c: cover property (wake_hit && in_sleep);
  txd_timeout_c: cover property ($rose(txd_hit));
  uv_c: cover property (supply_low_active && mode_normal);
  bus_clamp_c: cover property ($rose(bus_watch.hit));

endmodule

/* File: can_bus_model.sv */
// Far-side model: the CAN bus level seen by the receiver, with a wake pattern source.
// Assumes the design clock; the bus is dominant while any node or the clamp drives it.
`timescale 1ns/1ps
module can_bus_model (
  // Clock.
  input wire logic clk,
  // Bus sources.
  input wire logic drive_dominant,
  input wire logic clamp,
  // Pattern request.
  input wire logic [9:0] dom_len,
  input wire logic [9:0] rec_len,
  input wire logic start,
  // Bus level.
  output logic bus_dominant
);
  int cnt = 0;
  logic pattern;
  // Dominant, recessive, dominant phases of the requested lengths.
  assign pattern = (cnt >= 1 && cnt <= dom_len) || (cnt > dom_len + rec_len);
  assign bus_dominant = drive_dominant | clamp | pattern;
  always @(posedge clk) begin
    if (start && cnt == 0) begin
      cnt <= 1;
    end else if (cnt != 0 && cnt < 2 * dom_len + rec_len) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
  end
endmodule

/* File: can_trx_ctrl_tb_top.sv */
// Self-checking testbench of the CAN transceiver mode, wake and fault control.
// Assumes a 250 MHz clock and shortened time-outs set through the top parameters.
`timescale 1ns/1ps
module can_trx_ctrl_tb_top;
  localparam int TXD = 40;
  localparam int BUS = 80;
  localparam int SIL = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  can_ctrl_pkg::device_mode_e device_mode = can_ctrl_pkg::dev_normal;
  logic wd_on_wake = 1'b1;
  logic wd_enabled = 1'b0;
  logic mode_write = 1'b0;
  logic [1:0] mode_value = 2'h0;
  logic [3:0] clr = 4'h0;
  logic txd = 1'b1;
  logic supply_low = 1'b0;
  logic clamp = 1'b0;
  logic start = 1'b0;
  logic [9:0] dom_len = 10'h0;
  logic [9:0] rec_len = 10'h0;
  logic bus_dom;
  logic [1:0] transceiver_mode;
  logic bus_receive_out;
  logic drive;
  can_ctrl_pkg::termination_e termination;
  logic can_fail_flag;
  logic uv_flag;
  logic wake_source_status;
  logic irq_out_n;
  logic restart_request;
  logic wd_request;
  int miscompares = 0;
  int tests_run = 0;
  int restarts = 0;
  int wd_reqs = 0;

  can_trx_ctrl #(.TXD_TIMEOUT_CYCLES(TXD), .BUS_TIMEOUT_CYCLES(BUS), .SILENCE_CYCLES(SIL)) DUT (
    .clk(clk), .reset_n(reset_n), .device_mode(device_mode),
    .watchdog_on_bus_wake(wd_on_wake), .watchdog_enabled(wd_enabled),
    .mode_write(mode_write), .mode_value(mode_value), .can_fail_clear(clr[3]),
    .supply_low_clear(clr[2]), .wake_status_clear(clr[1]), .irq_clear(clr[0]),
    .bus_transmit_in(txd), .bus_dominant_in(bus_dom), .transceiver_supply_low(supply_low),
    .transceiver_mode(transceiver_mode), .bus_receive_out(bus_receive_out),
    .bus_drive_dominant(drive), .termination(termination), .can_fail_flag(can_fail_flag),
    .transceiver_supply_low_flag(uv_flag), .wake_source_status(wake_source_status),
    .irq_out_n(irq_out_n), .restart_request(restart_request),
    .watchdog_enable_request(wd_request));

  can_bus_model bus (.clk(clk), .drive_dominant(drive), .clamp(clamp), .dom_len(dom_len),
    .rec_len(rec_len), .start(start), .bus_dominant(bus_dom));

  initial begin
    forever #2 clk = ~clk;
  end

  // Counts one-cycle request pulses in mid-cycle.
  always @(negedge clk) begin
    if (restart_request === 1'b1) restarts++;
    if (wd_request === 1'b1) wd_reqs++;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
`define CHK(g, e) check(64'(g), 64'(e))

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic write_mode(input logic [1:0] v);
    @(negedge clk) mode_write = 1'b1;
    mode_value = v;
    @(negedge clk) mode_write = 1'b0;
    cyc(1);
  endtask

  task automatic clear(input logic [3:0] m);
    @(negedge clk) clr = m;
    @(negedge clk) clr = 4'h0;
  endtask

  task automatic wake(input logic [9:0] d, input logic [9:0] r);
    @(negedge clk) start = 1'b1;
    dom_len = d;
    rec_len = r;
    @(negedge clk) start = 1'b0;
    cyc(2 * d + r + 6);
  endtask

  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end

  initial begin
    cyc(8);
    reset_n = 1'b1;
    cyc(1);
    `CHK(transceiver_mode, can_ctrl_pkg::TRX_OFF);
    `CHK({bus_receive_out, irq_out_n}, 2'h3);
    `CHK(termination, can_ctrl_pkg::term_floating);
    wake(10'd200, 10'd200);
    `CHK({irq_out_n, wake_source_status}, 2'h2);
    device_mode = can_ctrl_pkg::dev_stop;
    write_mode(can_ctrl_pkg::TRX_WAKE);
    `CHK(transceiver_mode, can_ctrl_pkg::TRX_WAKE);
    cyc(SIL - 6);
    `CHK(termination, can_ctrl_pkg::term_floating);
    cyc(10);
    `CHK(termination, can_ctrl_pkg::term_ground);
    wake(10'd200, 10'd100);
    wake(10'd460, 10'd200);
    `CHK(irq_out_n, 1'b1);
    wake(10'd200, 10'd200);
    `CHK({irq_out_n, wake_source_status, bus_receive_out}, 3'h2);
    `CHK(transceiver_mode, can_ctrl_pkg::TRX_WAKE);
    `CHK(termination, can_ctrl_pkg::term_fixed_2v5);
    `CHK({restarts[7:0], wd_reqs[7:0]}, 16'h0001);
    cyc(50);
    `CHK(bus_receive_out, 1'b0);
    clear(4'h3);
    `CHK({irq_out_n, wake_source_status}, 2'h2);
    wd_enabled = 1'b1;
    write_mode(can_ctrl_pkg::TRX_OFF);
    write_mode(can_ctrl_pkg::TRX_WAKE);
    wake(10'd200, 10'd200);
    `CHK({wd_reqs[7:0], irq_out_n}, 9'h002);
    clear(4'h3);
    device_mode = can_ctrl_pkg::dev_sleep;
    cyc(2);
    wake(10'd200, 10'd200);
    `CHK({restarts[7:0], irq_out_n, bus_receive_out}, 10'h006);
    `CHK(wake_source_status, 1'b1);
    write_mode(can_ctrl_pkg::TRX_OFF);
    `CHK(bus_receive_out, 1'b1);
    device_mode = can_ctrl_pkg::dev_fail_safe;
    cyc(2);
    write_mode(can_ctrl_pkg::TRX_NORMAL);
    `CHK(transceiver_mode, can_ctrl_pkg::TRX_WAKE);
    wake(10'd200, 10'd200);
    `CHK({restarts[7:0], irq_out_n}, 9'h005);
    device_mode = can_ctrl_pkg::dev_restart;
    write_mode(can_ctrl_pkg::TRX_OFF);
    write_mode(can_ctrl_pkg::TRX_WAKE);
    wake(10'd200, 10'd200);
    `CHK({restarts[7:0], irq_out_n}, 9'h007);
    device_mode = can_ctrl_pkg::dev_normal;
    write_mode(can_ctrl_pkg::TRX_OFF);
    write_mode(can_ctrl_pkg::TRX_WAKE);
    wake(10'd200, 10'd200);
    `CHK({restarts[7:0], irq_out_n}, 9'h006);
    supply_low = 1'b1;
    cyc(3);
    `CHK(uv_flag, 1'b0);
    supply_low = 1'b0;
    write_mode(can_ctrl_pkg::TRX_NORMAL);
    `CHK(termination, can_ctrl_pkg::term_half_supply);
    txd = 1'b0;
    cyc(10);
    `CHK(drive, 1'b0);
    txd = 1'b1;
    cyc(can_ctrl_pkg::ENABLE_CYCLES + 5);
    txd = 1'b0;
    cyc(2);
    `CHK(drive, 1'b1);
    cyc(TXD + 3);
    `CHK({drive, can_fail_flag, transceiver_mode}, 4'h7);
    txd = 1'b1;
    clear(4'h8);
    `CHK(can_fail_flag, 1'b0);
    txd = 1'b0;
    cyc(2);
    `CHK(drive, 1'b1);
    txd = 1'b1;
    clamp = 1'b1;
    cyc(3);
    `CHK(bus_receive_out, 1'b0);
    cyc(BUS + 3);
    `CHK({can_fail_flag, transceiver_mode}, 3'h7);
    clamp = 1'b0;
    clear(4'h8);
    supply_low = 1'b1;
    txd = 1'b0;
    cyc(3);
    `CHK({drive, uv_flag}, 2'h1);
    supply_low = 1'b0;
    cyc(3);
    `CHK(drive, 1'b1);
    txd = 1'b1;
    write_mode(can_ctrl_pkg::TRX_RX_ONLY);
    supply_low = 1'b1;
    clamp = 1'b1;
    cyc(3);
    `CHK(termination, can_ctrl_pkg::term_fixed_2v5);
    `CHK(bus_receive_out, 1'b0);
    clamp = 1'b0;
    cyc(3);
    `CHK(bus_receive_out, 1'b1);
    supply_low = 1'b0;
    write_mode(can_ctrl_pkg::TRX_OFF);
    `CHK(termination, can_ctrl_pkg::term_floating);
    print_verdict();
  end
endmodule
